// ### core/svlm_pkg.sv
// constants and types shared by the supply level monitor
package svlm_pkg;
   // register indices on the plain port; the index is the address
   localparam logic [2:0] SVLM_CTRL_ADDR   = 3'h0;
   localparam logic [2:0] SVLM_STAT_ADDR   = 3'h1;
   localparam logic [2:0] SVLM_IRQ_ST_ADDR = 3'h2;
   localparam logic [2:0] SVLM_IRQ_EN_ADDR = 3'h3;
   localparam logic [2:0] SVLM_IRQ_CL_ADDR = 3'h4;
   // field positions
   localparam int SVLM_TRIM_LSB  = 0;
   localparam int SVLM_RANGE_BIT = 3;
   localparam int SVLM_EN_BIT    = 0;
   localparam int SVLM_VALID_BIT = 1;
   localparam int SVLM_BELOW_BIT = 2;
   localparam int SVLM_IRQ_BIT   = 2;
   // reset values
   localparam logic [2:0] SVLM_TRIM_RST  = 3'h0;
   localparam logic       SVLM_RANGE_RST = 1'b0;
   localparam logic       SVLM_EN_RST    = 1'b0;
   // timing
   localparam int SVLM_CLK_MHZ     = 125;
   localparam int SVLM_SETTLE_US   = 2000;
   localparam int SVLM_SETTLE_CYC  = SVLM_SETTLE_US * SVLM_CLK_MHZ;
   localparam int SVLM_CNT_W       = 18;
   typedef enum logic [1:0] {
      SVLM_OFF    = 2'b00,
      SVLM_SETTLE = 2'b01,
      SVLM_VALID  = 2'b11
   } svlm_state_type;
endpackage

// ### core/svlm_edge_irq.sv
// sticky event capture on a rising edge, with clear and edge pulse; the enable input is unused
`timescale 1ns/1ps
module svlm_edge_irq (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic level,
   input  wire logic arm,
   input  wire logic clear,
   input  wire logic enable,
   output logic      sticky_reg,
   output logic      edge_pulse
);
   logic level_d_reg;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         level_d_reg <= 1'b0;
      end else begin
         level_d_reg <= level & arm;
      end
   end

   // only a new rising edge fires; a steady high level stays quiet
   assign edge_pulse = arm & level & ~level_d_reg; // RULE5

   // set wins over clear
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sticky_reg <= 1'b0;
      end else if (edge_pulse) begin
         sticky_reg <= 1'b1;
      end else if (clear) begin
         sticky_reg <= 1'b0;
      end
   end

   logic unused_enable;
   assign unused_enable = enable;
endmodule

// ### core/svlm_top.sv
// supply level monitor: control, settling timer, status and interrupt
// Overview of operation
// RULE1: enable bit powers detector on or off
// RULE2: setting enable starts measurement immediately
// RULE3: valid flag rises 2 ms after enable
// RULE4: interrupts only while valid and enabled
// RULE5: one request per rising edge of result
// RULE6: software trusts result only while valid
// RULE7: status bit 2 shows supply below threshold
// RULE8: three-bit trim selects eight threshold steps
// RULE9: control bit 3 selects detection range
// RULE10: request drives mid-priority irq bit 2
// RULE11: disabled detector held fully powered down
// RULE12: disable clears flags, restarts settling wait
`timescale 1ns/1ps
module svlm_top
   import svlm_pkg::*;
#(
   parameter int SETTLE_CYCLES = SVLM_SETTLE_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       comp_below,
   output logic            det_power_on,
   output logic            det_range,
   output logic      [2:0] det_trim,
   output logic            supply_low_irq,
   output logic            irq
);
   // control fields
   logic [2:0]            trim_reg;
   logic                  range_reg;
   logic                  enable_reg;
   logic                  irq_en_reg;
   // settling sequence
   svlm_state_type        state_reg;
   logic [SVLM_CNT_W-1:0] count_reg;
   logic                  settle_done;
   // comparator synchroniser
   logic                  below_s1_reg;
   logic                  below_s2_reg;
   // register port decode
   logic                  ctrl_wr;
   logic                  stat_wr;
   logic                  irq_en_wr;
   logic                  irq_clr_wr;
   // read words
   logic [7:0]            ctrl_word;
   logic [7:0]            stat_word;
   logic [7:0]            irq_st_word;
   logic [7:0]            irq_en_word;
   logic [7:0]            read_word;
   // status and interrupt
   logic                  valid_flag;
   logic                  below_flag;
   logic                  irq_arm;
   logic                  irq_clear;
   logic                  irq_sticky;
   logic                  edge_pulse;

   ////////////////////////////////////////////////////////////////////////////
   // write decode; unmapped indices are ignored
   assign ctrl_wr    = reg_wr && (reg_addr == SVLM_CTRL_ADDR);
   assign stat_wr    = reg_wr && (reg_addr == SVLM_STAT_ADDR);
   assign irq_en_wr  = reg_wr && (reg_addr == SVLM_IRQ_EN_ADDR);
   assign irq_clr_wr = reg_wr && (reg_addr == SVLM_IRQ_CL_ADDR);

   ////////////////////////////////////////////////////////////////////////////
   // control register: trim field
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         trim_reg <= SVLM_TRIM_RST;
      end else if (ctrl_wr) begin
         trim_reg <= reg_wdata[SVLM_TRIM_LSB +: 3]; // RULE8
      end
   end

   // control register: range bit
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         range_reg <= SVLM_RANGE_RST;
      end else if (ctrl_wr) begin
         range_reg <= reg_wdata[SVLM_RANGE_BIT]; // RULE9
      end
   end

   // status register: only the enable bit is writable
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         enable_reg <= SVLM_EN_RST;
      end else if (stat_wr) begin
         enable_reg <= reg_wdata[SVLM_EN_BIT]; // RULE1
      end
   end

   // interrupt enable register
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_en_reg <= 1'b0;
      end else if (irq_en_wr) begin
         irq_en_reg <= reg_wdata[SVLM_IRQ_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog detector controls
   // off removes all bias; trim and range are held, not gated
   assign det_power_on = enable_reg; // RULE11
   assign det_range    = range_reg; // RULE9
   assign det_trim     = trim_reg; // RULE8

   ////////////////////////////////////////////////////////////////////////////
   // comparator output is asynchronous to ref_clk
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         below_s1_reg <= 1'b0;
         below_s2_reg <= 1'b0;
      end else begin
         below_s1_reg <= comp_below;
         below_s2_reg <= below_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // settling sequence
   // counter parked at zero outside the wait, so a later
   // enable never inherits a part-used wait
   assign settle_done = (count_reg == SVLM_CNT_W'(SETTLE_CYCLES - 2));

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_reg <= '0;
      end else if (!enable_reg) begin
         count_reg <= '0; // RULE12
      end else if (state_reg == SVLM_SETTLE) begin
         count_reg <= count_reg + 1'b1;
      end else begin
         count_reg <= '0;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= SVLM_OFF;
      end else if (!enable_reg) begin
         state_reg <= SVLM_OFF; // RULE12
      end else begin
         unique case (state_reg)
            SVLM_OFF: begin
               state_reg <= SVLM_SETTLE; // RULE2
            end
            SVLM_SETTLE: begin
               if (settle_done) begin
                  state_reg <= SVLM_VALID; // RULE3
               end
            end
            SVLM_VALID: begin
               state_reg <= SVLM_VALID;
            end
            default: begin
               state_reg <= SVLM_OFF;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags
   // valid drops with the enable bit, not a cycle later
   assign valid_flag = (state_reg == SVLM_VALID) && enable_reg; // RULE3 RULE12
   // result masked to zero until valid so it never reads stale
   assign below_flag = valid_flag && below_s2_reg; // RULE7 RULE12

   ////////////////////////////////////////////////////////////////////////////
   // interrupt capture
   assign irq_arm   = valid_flag && enable_reg; // RULE4
   assign irq_clear = irq_clr_wr && reg_wdata[SVLM_IRQ_BIT];

   svlm_edge_irq u_edge (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .level      (below_flag),
      .arm        (irq_arm),
      .clear      (irq_clear),
      .enable     (irq_en_reg),
      .sticky_reg (irq_sticky),
      .edge_pulse (edge_pulse)
   );

   // pulse goes to the interrupt manager, level to polling software
   assign supply_low_irq = edge_pulse; // RULE10 RULE5
   assign irq            = irq_sticky && irq_en_reg;

   ////////////////////////////////////////////////////////////////////////////
   // read words; reserved bits read zero
   assign ctrl_word   = {4'h0, range_reg, trim_reg};
   assign stat_word   = {5'h00, below_flag, valid_flag, enable_reg}; // RULE6
   assign irq_st_word = {5'h00, irq_sticky, 2'h0};
   assign irq_en_word = {5'h00, irq_en_reg, 2'h0};

   always_comb begin
      unique case (reg_addr)
         SVLM_CTRL_ADDR: begin
            read_word = ctrl_word;
         end
         SVLM_STAT_ADDR: begin
            read_word = stat_word;
         end
         SVLM_IRQ_ST_ADDR: begin
            read_word = irq_st_word;
         end
         SVLM_IRQ_EN_ADDR: begin
            read_word = irq_en_word;
         end
         default: begin
            read_word = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port, data one cycle after strobe
   // zero outside the answer cycle, so a stale word never looks fresh
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= read_word;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// ### dv/svlm_props.sv
// port assertions for the supply level monitor
`timescale 1ns/1ps
module svlm_props
   import svlm_pkg::*;
#(
   parameter int SETTLE_CYCLES = SVLM_SETTLE_CYC
) (
   input wire logic       ref_clk,
   input wire logic       sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       det_power_on,
   input wire logic       det_range,
   input wire logic [2:0] det_trim,
   input wire logic       supply_low_irq
);
   int   on_cnt;
   logic settled;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         on_cnt <= 0;
      end else begin
         on_cnt <= det_power_on ? on_cnt + 1 : 0;
      end
   end
   // valid is internal, so rebuild it from time since power-on
   assign settled = det_power_on && on_cnt >= SETTLE_CYCLES;
   ////////////////////////////////////////////
   sequence s_stat_rd;
      reg_rd && reg_addr == SVLM_STAT_ADDR;
   endsequence
   a_power_follows: assert property (reg_wr && reg_addr == SVLM_STAT_ADDR |=> det_power_on == $past(reg_wdata[0]))
      else $error("power pin does not follow enable write");
   a_ctrl_pins: assert property (reg_wr && reg_addr == SVLM_CTRL_ADDR |=> {det_range, det_trim} == $past(reg_wdata[3:0]))
      else $error("range or trim pins wrong after write");
   a_ctrl_readback: assert property (reg_rd && reg_addr == SVLM_CTRL_ADDR |=> reg_rdata == {4'h0, $past(det_range), $past(det_trim)})
      else $error("control read back wrong");
   a_valid_timing: assert property (s_stat_rd |=> reg_rdata[1:0] == {$past(settled), $past(det_power_on)})
      else $error("valid or enable bit wrong");
   a_below_gated: assert property (s_stat_rd |=> reg_rdata[7:3] == 5'h00 && (!reg_rdata[2] || reg_rdata[1]))
      else $error("below flag shown without valid");
   a_off_clears: assert property (s_stat_rd and !det_power_on |=> reg_rdata[2:0] == 3'h0)
      else $error("flags stay set while disabled");
   a_irq_settled: assert property (supply_low_irq |-> settled)
      else $error("request before valid or while off");
   a_irq_one_pulse: assert property (supply_low_irq |=> !supply_low_irq)
      else $error("request longer than one cycle");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read");
endmodule
bind svlm_top svlm_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .det_power_on(det_power_on), .det_range(det_range), .det_trim(det_trim), .supply_low_irq(supply_low_irq));

// ### dv/tb_top.sv
// self-checking bench for the supply level monitor
`timescale 1ns/1ps
`define CMP(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top
   import svlm_pkg::*;
;
   logic       ref_clk, sys_rst, reg_wr, reg_rd, comp_below, det_power_on, det_range, supply_low_irq, irq;
   logic [2:0] reg_addr, det_trim;
   logic [7:0] reg_wdata, reg_rdata, w;
   int         error_cnt, n_compared, pulses, cyc;
   // short settle keeps the run small
   svlm_top #(.SETTLE_CYCLES(8)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_below(comp_below),
      .det_power_on(det_power_on), .det_range(det_range), .det_trim(det_trim), .supply_low_irq(supply_low_irq), .irq(irq));
   function automatic logic [7:0] stat_exp(input logic en, input logic val, input logic bel);
      return {5'h00, bel & val, val, en};
   endfunction
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic chk_rd(input logic [2:0] a, input logic [7:0] e, input string n);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      `CMP(n, e, reg_rdata)
   endtask
   task automatic comp_set(input logic v, input int wait_cyc);
      @(posedge ref_clk);
      comp_below <= v;
      repeat (wait_cyc) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   ////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // comb request is looked at away from the launching edge
   always @(negedge ref_clk) begin
      cyc++;
      pulses += int'(supply_low_irq === 1'b1);
      if (cyc == 2000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, comp_below} = 4'h8;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      void'($urandom(87));
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         w = (i == 0) ? 8'hff : 8'($urandom);
         wr(SVLM_CTRL_ADDR, w);
         chk_rd(SVLM_CTRL_ADDR, {4'h0, w[3:0]}, "control");
         `CMP("pins", w[3:0], {det_range, det_trim})
         wr(3'(5 + i % 3), w);
         chk_rd(3'(5 + i % 3), 8'h00, "unmapped");
      end
      wr(SVLM_IRQ_EN_ADDR, 8'h04);
      wr(SVLM_STAT_ADDR, 8'h01);
      `CMP("power", 1'b1, det_power_on)
      chk_rd(SVLM_STAT_ADDR, stat_exp(1, 0, 0), "settling");
      comp_set(1'b0, 8);
      chk_rd(SVLM_STAT_ADDR, stat_exp(1, 1, 0), "valid");
      comp_set(1'b1, 16);
      `CMP("one pulse", 1, pulses)
      `CMP("irq", 1'b1, irq)
      chk_rd(SVLM_STAT_ADDR, stat_exp(1, 1, 1), "below");
      wr(SVLM_IRQ_EN_ADDR, 8'h00);
      `CMP("masked", 1'b0, irq)
      chk_rd(SVLM_IRQ_ST_ADDR, 8'h04, "sticky");
      wr(SVLM_IRQ_CL_ADDR, 8'h04);
      chk_rd(SVLM_IRQ_ST_ADDR, 8'h00, "cleared");
      wr(SVLM_IRQ_EN_ADDR, 8'h04);
      comp_set(1'b0, 4);
      comp_set(1'b1, 6);
      `CMP("second edge", 2, pulses)
      wr(SVLM_STAT_ADDR, 8'h00);
      `CMP("off", 1'b0, det_power_on)
      chk_rd(SVLM_STAT_ADDR, 8'h00, "off flags");
      comp_set(1'b0, 4);
      comp_set(1'b1, 6);
      `CMP("off pulses", 2, pulses)
      wr(SVLM_STAT_ADDR, 8'h01);
      chk_rd(SVLM_STAT_ADDR, stat_exp(1, 0, 1), "restart");
      results();
   end
endmodule
